// File: rtl/dac_cmd_pkg.sv
// How it works
// RULE1 - While select is low, each rising serial clock shifts one input bit in.
// RULE2 - Select must stay low while bits are clocked; none are taken while high.
// RULE3 - Rising select ends the frame and executes the command in the shift register.
// RULE4 - Frames are 24 or 32 bits long; both lengths are accepted.
// RULE5 - Frame is command byte, two data bytes, optional fourth byte with 8-bit check.
// RULE6 - The check code applies only to 32-bit frames, never 24-bit frames.
// RULE7 - In a chain the host gives clock counts in multiples of 32; the port faults any count but 24 or 32 and passes no data on.
// RULE8 - Clock edges per frame are counted; an invalid count raises a fault.
// RULE9 - A write in a 32-bit frame is echoed whole during the next frame.
// RULE10 - A read in a 32-bit frame returns command byte and data next frame.
// RULE11 - A read in a 24-bit frame returns data only; leading eight bits ignored.
// RULE12 - Writes in 24-bit frames are not echoed.
// RULE13 - Channel commands: low nibble is channel number, high nibble is operation.
// RULE14 - Configuration and fault register accesses skip the check code even if enabled.
// RULE15 - Nibbles 0 to 3 write channel code, settings, offset, gain.
// RULE16 - Nibble 4 writes and updates, 5 writes and updates all, 6 only updates.
// RULE17 - Codes 70 to 76 write config, power-down, A/B, toggle, enable, mux, fault.
// RULE18 - Codes 78 to 7C: all code, code+update, settings, settings+update, update.
// RULE19 - Nibbles 8 to B read adjusted code, settings, offset, gain of a channel; code readback returns the unadjusted dac_code.
// RULE20 - Codes F0 to F7 read the global registers and thermal status.
// RULE21 - Reset returns all registers to defaults: span zero, codes zero.
// RULE22 - Update copies input registers to output registers and powers the channel up.
// RULE23 - The data field is sent most significant bit first.
// RULE24 - Serial output changes on falling serial clock, stable before the next rise.
// RULE25 - Unlisted first bytes, including all-ones, change nothing and update nothing.
package dac_cmd_pkg;
    localparam int NCH = 16;
    localparam logic [5:0] LEN_SHORT = 6'd24;
    localparam logic [5:0] LEN_LONG = 6'd32;
    localparam logic [5:0] CNT_MAX = 6'd63;
    localparam logic [3:0] OP_WR_CODE = 4'h0;
    localparam logic [3:0] OP_WR_SET = 4'h1;
    localparam logic [3:0] OP_WR_OFS = 4'h2;
    localparam logic [3:0] OP_WR_GAIN = 4'h3;
    localparam logic [3:0] OP_WR_UPD = 4'h4;
    localparam logic [3:0] OP_WR_UPD_ALL = 4'h5;
    localparam logic [3:0] OP_UPD = 4'h6;
    localparam logic [3:0] OP_WR_GLB = 4'h7;
    localparam logic [3:0] OP_RD_CODE = 4'h8;
    localparam logic [3:0] OP_RD_SET = 4'h9;
    localparam logic [3:0] OP_RD_OFS = 4'ha;
    localparam logic [3:0] OP_RD_GAIN = 4'hb;
    localparam logic [3:0] OP_RD_GLB = 4'hf;
    localparam logic [3:0] G_CFG = 4'h0;
    localparam logic [3:0] G_PDN = 4'h1;
    localparam logic [3:0] G_AB = 4'h2;
    localparam logic [3:0] G_TOG = 4'h3;
    localparam logic [3:0] G_TEN = 4'h4;
    localparam logic [3:0] G_MUX = 4'h5;
    localparam logic [3:0] G_FLT = 4'h6;
    localparam logic [3:0] G_THM = 4'h7;
    localparam logic [3:0] G_CODE_ALL = 4'h8;
    localparam logic [3:0] G_CODE_UPD_ALL = 4'h9;
    localparam logic [3:0] G_SET_ALL = 4'ha;
    localparam logic [3:0] G_SET_UPD_ALL = 4'hb;
    localparam logic [3:0] G_UPD_ALL = 4'hc;
    localparam int FLT_COUNT_BIT = 0;
    localparam int CFG_CRC_BIT = 0;
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [15:0] SET_RESET = 16'h0000;
    localparam logic [15:0] REG_RESET = 16'h0000;

    typedef struct packed {
        logic [3:0] op;
        logic [3:0] addr;
        logic [15:0] data;
        logic [7:0] crc;
    } frame_t;

    typedef logic [NCH-1:0][15:0] bank_t;

    typedef struct packed {
        logic [5:0] bit_cnt;
        logic [31:0] in_sr;
        logic [31:0] out_sr;
        logic sout;
        logic frame_err;
        logic crc_due;
        bank_t code_in;
        bank_t set_in;
        bank_t dac_code;
        bank_t dac_set;
        bank_t offset;
        bank_t gain;
        logic [15:0] cfg;
        logic [15:0] pdown;
        logic [15:0] ab_sel;
        logic [15:0] sw_tog;
        logic [15:0] tog_en;
        logic [15:0] mux;
        logic [15:0] fault;
    } port_state_t;
endpackage

// File: rtl/dac_serial_command_port.sv
`timescale 1ns/1ps
module dac_serial_command_port import dac_cmd_pkg::*; (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Serial link pins
    input wire logic serial_clk_i,
    input wire logic select_and_load_n_i,
    input wire logic serial_in_i,
    output logic serial_out_o,
    // Status from the analog side
    input wire logic thermal_i,
    // Register contents towards the converter
    output bank_t dac_code_o,
    output bank_t dac_set_o,
    output bank_t offset_o,
    output bank_t gain_o,
    output logic [15:0] config_o,
    output logic [15:0] pdown_o,
    output logic [15:0] ab_sel_o,
    output logic [15:0] sw_toggle_o,
    output logic [15:0] toggle_en_o,
    output logic [15:0] mux_o,
    output logic [15:0] fault_o,
    // Frame status
    output logic frame_err_o,
    output logic crc_due_o
);
    port_state_t st_r;
    port_state_t st_nxt;
    logic [2:0] lvl;
    logic [2:0] rise;
    logic [2:0] fall;
    logic sck_rise;
    logic sck_fall;
    logic sel_n;
    logic frame_end;
    logic cnt_ok;
    logic is_long;
    frame_t w;
    logic known;
    logic is_rd;
    logic [15:0] rdata;

    // Pin order: 0 serial clock, 1 select, 2 data; select idles high
    pin_sync #(.W(3), .INIT(3'h2)) u_sync (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .pin_i({serial_in_i, select_and_load_n_i, serial_clk_i}),
        .level_o(lvl),
        .rise_o(rise),
        .fall_o(fall)
    );

    assign sck_rise = rise[0];
    assign sck_fall = fall[0];
    assign sel_n = lvl[1];
    assign frame_end = rise[1]; // RULE3
    assign is_long = (st_r.bit_cnt == LEN_LONG);
    assign cnt_ok = is_long || (st_r.bit_cnt == LEN_SHORT); // RULE4 RULE8
    // Short frames are left-aligned so both lengths decode alike
    assign w = is_long ? st_r.in_sr : {st_r.in_sr[23:0], 8'h00}; // RULE5 RULE23
    assign is_rd = w.op[3];

    // Decode which first bytes are listed commands and what a read returns
    always_comb begin
        known = 1'b0;
        rdata = 16'h0000;
        case (w.op) // RULE13
            OP_WR_CODE, OP_WR_SET, OP_WR_OFS, OP_WR_GAIN,
            OP_WR_UPD, OP_WR_UPD_ALL, OP_UPD: begin
                known = 1'b1;
            end
            OP_WR_GLB: begin
                known = (w.addr <= G_FLT) || ((w.addr >= G_CODE_ALL) && (w.addr <= G_UPD_ALL));
            end
            OP_RD_CODE: begin
                known = 1'b1;
                rdata = st_r.dac_code[w.addr]; // RULE19
            end
            OP_RD_SET: begin
                known = 1'b1;
                rdata = st_r.set_in[w.addr];
            end
            OP_RD_OFS: begin
                known = 1'b1;
                rdata = st_r.offset[w.addr];
            end
            OP_RD_GAIN: begin
                known = 1'b1;
                rdata = st_r.gain[w.addr];
            end
            OP_RD_GLB: begin
                known = (w.addr <= G_THM); // RULE20
                case (w.addr)
                    G_CFG: rdata = st_r.cfg;
                    G_PDN: rdata = st_r.pdown;
                    G_AB: rdata = st_r.ab_sel;
                    G_TOG: rdata = st_r.sw_tog;
                    G_TEN: rdata = st_r.tog_en;
                    G_MUX: rdata = st_r.mux;
                    G_FLT: rdata = st_r.fault;
                    G_THM: rdata = {15'h0000, thermal_i};
                    default: rdata = 16'h0000;
                endcase
            end
            default: known = 1'b0; // RULE25
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.crc_due = 1'b0;
        if (frame_end) begin
            st_nxt.bit_cnt = 6'd0;
            st_nxt.out_sr = 32'h0000_0000;
            if (!cnt_ok) begin
                // Bad frames are dropped whole so a slipped clock cannot corrupt a register
                st_nxt.frame_err = 1'b1; // RULE8
                st_nxt.fault[FLT_COUNT_BIT] = 1'b1;
            end else begin
                st_nxt.frame_err = 1'b0;
                // Config and fault accesses are exempt from the check code
                st_nxt.crc_due = is_long && st_r.cfg[CFG_CRC_BIT] && known &&
                    !((w.op == OP_WR_GLB || w.op == OP_RD_GLB) &&
                      (w.addr == G_CFG || w.addr == G_FLT)); // RULE6 RULE14
                case (w.op)
                    OP_WR_CODE: st_nxt.code_in[w.addr] = w.data; // RULE15
                    OP_WR_SET: st_nxt.set_in[w.addr] = w.data;
                    OP_WR_OFS: st_nxt.offset[w.addr] = w.data;
                    OP_WR_GAIN: st_nxt.gain[w.addr] = w.data;
                    OP_WR_UPD: begin
                        st_nxt.code_in[w.addr] = w.data; // RULE16
                        st_nxt.dac_code[w.addr] = w.data; // RULE22
                        st_nxt.dac_set[w.addr] = st_r.set_in[w.addr];
                        st_nxt.pdown[w.addr] = 1'b0;
                    end
                    OP_WR_UPD_ALL: begin
                        st_nxt.code_in[w.addr] = w.data; // RULE16
                        st_nxt.dac_code = st_nxt.code_in; // RULE22
                        st_nxt.dac_set = st_r.set_in;
                        st_nxt.pdown = 16'h0000;
                    end
                    OP_UPD: begin
                        st_nxt.dac_code[w.addr] = st_r.code_in[w.addr]; // RULE16 RULE22
                        st_nxt.dac_set[w.addr] = st_r.set_in[w.addr];
                        st_nxt.pdown[w.addr] = 1'b0;
                    end
                    OP_WR_GLB: begin
                        case (w.addr) // RULE17 RULE18
                            G_CFG: st_nxt.cfg = w.data;
                            G_PDN: st_nxt.pdown = w.data;
                            G_AB: st_nxt.ab_sel = w.data;
                            G_TOG: st_nxt.sw_tog = w.data;
                            G_TEN: st_nxt.tog_en = w.data;
                            G_MUX: st_nxt.mux = w.data;
                            G_FLT: st_nxt.fault = w.data;
                            G_CODE_ALL, G_CODE_UPD_ALL: begin
                                for (int i = 0; i < NCH; i++) begin
                                    st_nxt.code_in[i] = w.data;
                                end
                            end
                            G_SET_ALL, G_SET_UPD_ALL: begin
                                for (int i = 0; i < NCH; i++) begin
                                    st_nxt.set_in[i] = w.data;
                                end
                            end
                            default: ;
                        endcase
                        if (w.addr == G_CODE_UPD_ALL || w.addr == G_SET_UPD_ALL ||
                            w.addr == G_UPD_ALL) begin
                            st_nxt.dac_code = st_nxt.code_in; // RULE22
                            st_nxt.dac_set = st_nxt.set_in;
                            st_nxt.pdown = 16'h0000;
                        end
                    end
                    default: ;
                endcase
                if (known && !is_rd && is_long) begin
                    st_nxt.out_sr = st_r.in_sr; // RULE9 RULE12
                end else if (known && is_rd) begin
                    if (is_long) begin
                        st_nxt.out_sr = {w.op, w.addr, rdata, 8'h00}; // RULE10
                    end else begin
                        st_nxt.out_sr = {8'h00, rdata, 8'h00}; // RULE11
                    end
                end
            end
            st_nxt.sout = st_nxt.out_sr[31];
        end else if (!sel_n) begin // RULE2
            if (sck_rise) begin
                st_nxt.in_sr = {st_r.in_sr[30:0], lvl[2]}; // RULE1
                if (st_r.bit_cnt != CNT_MAX) begin
                    st_nxt.bit_cnt = st_r.bit_cnt + 6'd1; // RULE8
                end
            end
            if (sck_fall) begin
                // Changing on the falling edge gives the host half a period of setup
                st_nxt.out_sr = {st_r.out_sr[30:0], 1'b0}; // RULE24
                st_nxt.sout = st_r.out_sr[30];
            end
        end else begin
            st_nxt.bit_cnt = 6'd0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_r <= '0; // RULE21
            st_r.code_in <= {NCH{CODE_RESET}};
            st_r.dac_code <= {NCH{CODE_RESET}};
            st_r.set_in <= {NCH{SET_RESET}};
            st_r.dac_set <= {NCH{SET_RESET}};
            st_r.fault <= REG_RESET;
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    assign serial_out_o = st_r.sout;
    assign dac_code_o = st_r.dac_code;
    assign dac_set_o = st_r.dac_set;
    assign offset_o = st_r.offset;
    assign gain_o = st_r.gain;
    assign config_o = st_r.cfg;
    assign pdown_o = st_r.pdown;
    assign ab_sel_o = st_r.ab_sel;
    assign sw_toggle_o = st_r.sw_tog;
    assign toggle_en_o = st_r.tog_en;
    assign mux_o = st_r.mux;
    assign fault_o = st_r.fault;
    assign frame_err_o = st_r.frame_err;
    assign crc_due_o = st_r.crc_due;

    chk_shift_on_rise: assert property ( // RULE1
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && !frame_end && !sel_n && sck_rise) |=> (st_r.in_sr[0] == $past(lvl[2])))
        else $error("input bit not shifted in");

    chk_idle_no_count: assert property ( // RULE2
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && sel_n) |=> (st_r.bit_cnt == 6'd0))
        else $error("bits counted while select high");

    chk_bad_count: assert property ( // RULE8
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && !cnt_ok) |=> (frame_err_o && fault_o[FLT_COUNT_BIT]))
        else $error("bad clock count not flagged");

    chk_write_echo: assert property ( // RULE9
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && is_long && known && !is_rd)
        |=> (st_r.out_sr == $past(st_r.in_sr)) && (serial_out_o == st_r.out_sr[31]))
        else $error("32-bit write not echoed");

    chk_short_no_echo: assert property ( // RULE12
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && (st_r.bit_cnt == LEN_SHORT) && !is_rd) |=> (st_r.out_sr == 32'h0))
        else $error("24-bit write echoed");

    chk_long_read: assert property ( // RULE10
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && is_long && known && is_rd)
        |=> (st_r.out_sr[31:8] == {$past(st_r.in_sr[31:24]), $past(rdata)}))
        else $error("32-bit read answer wrong");

    chk_update_one: assert property ( // RULE16
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && cnt_ok && w.op == OP_WR_UPD)
        |=> (st_r.dac_code[$past(w.addr)] == $past(w.data)) && !st_r.pdown[$past(w.addr)])
        else $error("write and update failed");

    chk_nop_quiet: assert property ( // RULE25
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && w.op == OP_RD_GLB && w.addr == 4'hf)
        |=> $stable(st_r.dac_code) && $stable(st_r.code_in) && $stable(st_r.pdown))
        else $error("no-operation changed state");

    chk_out_on_fall: assert property ( // RULE24
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && !frame_end && !sel_n && sck_fall) |=> (serial_out_o == $past(st_r.out_sr[30])))
        else $error("serial output not advanced on fall");

    chk_err_clears: assert property ( // RULE4
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && cnt_ok) |=> !frame_err_o)
        else $error("good frame left count error set");

    chk_short_no_check: assert property ( // RULE6
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && !is_long) |=> !crc_due_o)
        else $error("check code asked for on short frame");

    chk_exempt_regs: assert property ( // RULE14
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && (w.op == OP_WR_GLB || w.op == OP_RD_GLB) &&
         (w.addr == G_CFG || w.addr == G_FLT)) |=> !crc_due_o)
        else $error("config or fault access asked for check code");

    chk_short_read: assert property ( // RULE11
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && (st_r.bit_cnt == LEN_SHORT) && known && is_rd)
        |=> (st_r.out_sr[31:8] == {8'h00, $past(rdata)}))
        else $error("24-bit read answer wrong");

    chk_update_all: assert property ( // RULE18
        @(posedge clk_i) disable iff (!resetn_i)
        (ce_i && frame_end && cnt_ok && w.op == OP_WR_GLB && w.addr == G_UPD_ALL)
        |=> (st_r.dac_code == $past(st_r.code_in)) && (st_r.pdown == 16'h0000))
        else $error("update of all channels failed");
endmodule // dac_serial_command_port

// File: rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync import dac_cmd_pkg::*; #(
    parameter int W = 3,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // Pins and their sampled form
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } sync_t;
    sync_t st_r;
    sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_r <= '{s1: INIT, s2: INIT, s3: INIT};
        end else if (ce_i) begin
            st_r <= st_nxt;
        end
    end

    // Edges come from the second and third stages only, never the first
    for (genvar i = 0; i < W; i++) begin : g_edge
        assign level_o[i] = st_r.s2[i];
        assign rise_o[i] = st_r.s2[i] & ~st_r.s3[i];
        assign fall_o[i] = ~st_r.s2[i] & st_r.s3[i];
    end
endmodule // pin_sync

// File: sim/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
    // Link pins towards the port
    output logic sck_o,
    output logic sel_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    // Half period of the serial clock, slower than the 3-cycle synchroniser needs
    localparam time HALF = 160;

    // Serial clock starts low and returns low after every frame and every stray burst
    initial begin
        sck_o = 1'b0;
        sel_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // Word is left aligned: short frames send only its upper bits
    task automatic xfer(input int nbits, input logic [31:0] word, output logic [31:0] reply);
        reply = '0;
        sel_n_o = 1'b0;
        #HALF;
        for (int i = 0; i < nbits; i++) begin
            sdi_o = word[31-i];
            #HALF;
            reply = {reply[30:0], sdo_i};
            sck_o = 1'b1;
            #HALF;
            sck_o = 1'b0;
        end
        #HALF;
        sel_n_o = 1'b1;
        // Released data line must not keep looking valid
        sdi_o = ~sdi_o;
        #(3*HALF);
    endtask

    // Clock edges with the port deselected, only when a scenario asks for them
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            #HALF sck_o = 1'b1;
            #HALF sck_o = 1'b0;
        end
    endtask
endmodule // host_link_model

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench import dac_cmd_pkg::*; ;
    logic clk_i, resetn_i, ce_i, thermal_i, sck, sel_n, serial_in, serial_out, frame_err, crc_due;
    bank_t dac_code, dac_set, offset, gain;
    logic [15:0] cfg, pdn, absel, swtog, togen, mux, flt;
    logic [31:0] rep;
    int err_total, n_checks, crc_cnt;
    wire logic [6:0][15:0] glb = {flt, mux, togen, swtog, absel, pdn, cfg};

    dac_serial_command_port dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .serial_clk_i(sck), .select_and_load_n_i(sel_n), .serial_in_i(serial_in),
        .serial_out_o(serial_out), .thermal_i(thermal_i), .dac_code_o(dac_code),
        .dac_set_o(dac_set), .offset_o(offset), .gain_o(gain), .config_o(cfg),
        .pdown_o(pdn), .ab_sel_o(absel), .sw_toggle_o(swtog), .toggle_en_o(togen),
        .mux_o(mux), .fault_o(flt), .frame_err_o(frame_err), .crc_due_o(crc_due));
    host_link_model host_u (.sck_o(sck), .sel_n_o(sel_n), .sdi_o(serial_in), .sdo_i(serial_out));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Counted mid-cycle, where the one-cycle pulse is settled
    always @(negedge clk_i) if (crc_due === 1'b1) crc_cnt++;

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        chk_val({31'h0, got}, {31'h0, exp});
    endtask

    task automatic report_and_stop();
        if (err_total == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic fr(input int n, input logic [31:0] w);
        // Start off the clock edge so no pin moves in the sampling time step
        @(posedge clk_i);
        #2 host_u.xfer(n, w, rep);
    endtask

    task automatic t_reset();
        for (int c = 0; c < NCH; c++) begin
            chk_val({dac_code[c], dac_set[c]}, 32'h0);
        end
        chk_val({pdn, cfg}, 32'h0);
        chk_flag(frame_err, 1'b0);
    endtask

    task automatic t_write_echo();
        fr(32, 32'h43123400);
        chk_val({16'h0, dac_code[3]}, 32'h1234);
        fr(32, 32'h05abcd00);
        chk_val(rep, 32'h43123400);
        chk_val({16'h0, dac_code[5]}, 32'h0);
        fr(32, 32'h71ffff00);
        chk_val({16'h0, pdn}, 32'hffff);
        fr(32, 32'h65000000);
        chk_val({dac_code[5], pdn}, 32'habcdffdf);
        fr(32, 32'h4fffff00);
        chk_val({dac_code[15], pdn}, 32'hffff7fdf);
        fr(32, 32'h57077700);
        chk_val({dac_code[7], pdn}, 32'h07770000);
    endtask

    task automatic t_channel_regs();
        fr(32, 32'h11000400);
        fr(32, 32'h21111100);
        fr(32, 32'h31222200);
        chk_val({offset[1], gain[1]}, 32'h11112222);
        chk_val({16'h0, dac_set[1]}, 32'h0);
        fr(32, 32'h41012300);
        chk_val({dac_code[1], dac_set[1]}, 32'h01230004);
        fr(32, 32'h81000000);
        fr(32, 32'h91000000);
        chk_val(rep, 32'h81012300);
        fr(32, 32'ha1000000);
        chk_val(rep, 32'h91000400);
        fr(32, 32'hb1000000);
        chk_val(rep, 32'ha1111100);
        fr(32, 32'h780aaa00);
        chk_val(rep, 32'hb1222200);
        chk_val({16'h0, dac_code[9]}, 32'h0);
        fr(32, 32'h790bbb00);
        chk_val({dac_code[0], dac_code[15]}, 32'h0bbb0bbb);
        fr(32, 32'h7a000300);
        chk_val({16'h0, dac_set[0]}, 32'h0);
        fr(32, 32'h7b000200);
        chk_val({dac_set[0], dac_set[15]}, 32'h00020002);
        fr(32, 32'h7a000100);
        fr(32, 32'h7c000000);
        chk_val({dac_set[2], dac_set[1]}, 32'h00010001);
    endtask

    task automatic t_globals();
        logic [15:0] e;
        @(posedge clk_i);
        #2 thermal_i = 1'b1;
        for (int k = 0; k < 7; k++) begin
            e = 16'h1a50 + 16'h1000 * k[15:0];
            fr(24, {4'h7, k[3:0], e, 8'h00});
            chk_val({16'h0, glb[k]}, {16'h0, e});
        end
        for (int k = 0; k < 9; k++) begin
            e = 16'h1a50 + 16'h1000 * (k[15:0] - 16'h1);
            if (k == 8) e = 16'h0001;
            fr(32, {4'hf, k[3:0], 24'h0});
            if (k == 0) chk_val(rep, 32'h0);
            else chk_val(rep, {4'hf, 4'(k - 1), e, 8'h00});
        end
        fr(24, 32'hf5000000);
        fr(24, 32'hff000000);
        chk_val({16'h0, rep[15:0]}, 32'h6a50);
    endtask

    task automatic t_nop();
        fr(32, 32'hffffffff);
        fr(32, 32'h7d123400);
        fr(32, 32'hc0123400);
        chk_val(rep, 32'h0);
        fr(32, 32'hffffffff);
        chk_val(rep, 32'h0);
        chk_val({dac_code[3], cfg}, 32'h0bbb1a50);
    endtask

    task automatic t_bad_count();
        host_u.stray(5);
        fr(24, 32'h02555500);
        chk_flag(frame_err, 1'b0);
        fr(32, 32'h62000000);
        chk_val({16'h0, dac_code[2]}, 32'h5555);
        fr(20, 32'h43777700);
        chk_val({dac_code[3], 15'h0, flt[0]}, 32'h0bbb0001);
        chk_flag(frame_err, 1'b1);
        fr(31, 32'h43777700);
        chk_val({dac_code[3], 15'h0, frame_err}, 32'h0bbb0001);
        fr(24, 32'hff000000);
        chk_flag(frame_err, 1'b0);
    endtask

    task automatic t_crc();
        fr(32, 32'h70000100);
        crc_cnt = 0;
        fr(32, 32'h00000100);
        chk_val(crc_cnt, 32'h1);
        fr(24, 32'h00000200);
        fr(32, 32'hf6000000);
        fr(32, 32'h76000000);
        fr(32, 32'hf0000000);
        chk_val(crc_cnt, 32'h1);
        fr(32, 32'h70000000);
    endtask

    task automatic t_freeze();
        @(posedge clk_i);
        #2 ce_i = 1'b0;
        fr(32, 32'h3f999900);
        @(posedge clk_i);
        #2 ce_i = 1'b1;
        repeat (4) @(posedge clk_i);
        chk_val({16'h0, gain[15]}, 32'h0);
        fr(32, 32'h3f999900);
        chk_val({16'h0, gain[15]}, 32'h9999);
        @(posedge clk_i);
        #2 resetn_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #2 resetn_i = 1'b1;
        repeat (4) @(posedge clk_i);
        chk_val({16'h0, gain[15]}, 32'h0);
    endtask

    // Watchdog: a stuck run still ends in the one verdict
    initial begin
        repeat (90000) @(posedge clk_i);
        err_total++;
        report_and_stop();
    end

    initial begin
        err_total = 0;
        n_checks = 0;
        crc_cnt = 0;
        ce_i = 1'b1;
        thermal_i = 1'b0;
        resetn_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #2 resetn_i = 1'b1;
        repeat (4) @(posedge clk_i);
        t_reset();
        t_write_echo();
        t_channel_regs();
        t_globals();
        t_nop();
        t_bad_count();
        t_crc();
        t_freeze();
        report_and_stop();
    end
endmodule // testbench
